/* hw/nested_interrupt_acceptance.sv */
// Purpose: interrupt acceptance, nesting and deferral logic
// Assumes: sequencer reports one completed instruction per instrDone pulse
// Notes: registers reached over AXI4-Lite
// Behaviour
// - Trap instruction always raises software interrupt
// - Trap pushes status, PC, clears enable, vectors
// - Trap handlers return with trap-return instruction
// - Maskable nesting needs global enable set
// - Any acceptance clears global maskable enable
// - Enable instruction sets global maskable enable
// - Equal or higher priority nests when enabled
// - Lower priority never nests
// - Refused requests pend; one instruction after return
// - Non-maskable handler blocks all nesting; here it blocks NMI and maskable entry, a trap still nests
// - Priority flag zero high, one low
// - High in service admits NMI, enabled high
// - Low or idle admits both levels enabled
// - Listed instructions defer acceptance one instruction
// - Trap does not defer; NMI still accepted
// - Eligible when request set and mask clear
// - Accepted source priority copied into in-service flag
// - Higher programmed priority wins, then default
// - Latency seven to thirty-two clocks, low plus one
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module nested_interrupt_acceptance #(
  parameter int N = int_accept_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Peripheral request pulses
  input wire logic [N-1:0] srcEvent,
  input wire logic nmiEvent,
  // Instruction sequencer
  input wire logic instrDone,
  input wire logic [2:0] instrOp,
  output logic takeReq,
  output logic takeNmi,
  output logic takeTrap,
  output logic [7:0] vectorLo,
  output logic [7:0] vectorHi,
  output logic [7:0] pushedPsw,
  output logic maskableAcceptEnable,
  output logic inServicePriority,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int IW = $clog2(N);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef enum logic [1:0] {CTX_NONE, CTX_MASKABLE, CTX_NMI, CTX_TRAP} ctx_t;
  logic [N-1:0] requestFlag_q;
  logic [N-1:0] maskFlag_q;
  logic [N-1:0] sourcePriorityFlag_q;
  logic [7:0] psw_q;
  logic [7:0] pswStack_q [4];
  logic holdOp;
  logic nmiPend_q;
  logic [1:0] depth_q;
  ctx_t ctx_q;
  logic hold_q;
  logic nmiSvc_q;
  logic [7:0] nmiVec_q;
  logic awHave_q;
  logic wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic found;
  logic [IW-1:0] idx;
  logic winPrio;
  logic latBusy;
  logic latDone;
  logic [5:0] latCount;
  logic maskOk;
  logic nmiOk;
  logic boundary;
  logic acceptM;
  logic acceptN;
  logic isTrap;
  logic regWr;
  logic pswWr;
  logic [IW-1:0] accIdx_q;
  logic accNmi_q;
  logic accPrio_q;
  // ----------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------
  int_select #(.N(N)) u_sel (
    .request(requestFlag_q),
    .mask(maskFlag_q),
    .prio(sourcePriorityFlag_q),
    .found(found),
    .idx(idx),
    .winPrio(winPrio)
  );
  // ----------------------------------------------------------
  // Acceptance decision
  // ----------------------------------------------------------
  assign isTrap = instrDone && (int_accept_pkg::op_t'(instrOp) == int_accept_pkg::OP_TRAP);
  assign holdOp = instrDone && (int_accept_pkg::op_t'(instrOp) inside {int_accept_pkg::OP_TRAP_RET,
    int_accept_pkg::OP_INT_RET, int_accept_pkg::OP_ENABLE, int_accept_pkg::OP_DISABLE,
    int_accept_pkg::OP_HOLD});
  assign boundary = instrDone && !holdOp && !hold_q && !latBusy;
  assign maskOk = found && psw_q[int_accept_pkg::PSW_IE_BIT] && !isTrap && !nmiSvc_q &&
    (psw_q[int_accept_pkg::PSW_ISP_BIT] || !winPrio);
  assign nmiOk = nmiPend_q && !nmiSvc_q;
  assign acceptN = boundary && nmiOk;
  assign acceptM = boundary && !nmiOk && maskOk;
  // high priority 7 clocks minimum, low one more
  assign latCount = acceptN ? 6'(int_accept_pkg::ACCEPT_CYCLES) :
    6'(int_accept_pkg::ACCEPT_CYCLES + (winPrio ? 1 : 0));
  latency_counter #(.W(6)) u_lat (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(acceptN || acceptM),
    .count(latCount),
    .busy(latBusy),
    .done(latDone)
  );
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      accIdx_q <= '0;
      accNmi_q <= 1'b0;
      accPrio_q <= 1'b1;
    end else if (acceptN || acceptM) begin
      accIdx_q <= idx;
      accNmi_q <= acceptN;
      accPrio_q <= winPrio;
    end
  end
  // Deferral of the next instruction boundary after a register write
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else if (regWr) begin
      hold_q <= 1'b1;
    end else if (instrDone) begin
      hold_q <= 1'b0;
    end
  end
  // Status word stack, one entry per nesting level
  always_ff @(posedge ref_clk) begin
    if (isTrap || acceptN || acceptM) begin
      pswStack_q[depth_q] <= psw_q;
    end
  end
  // ----------------------------------------------------------
  // Status word and service context
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      psw_q <= int_accept_pkg::PSW_RESET;
      depth_q <= '0;
      ctx_q <= CTX_NONE;
      nmiSvc_q <= 1'b0;
    end else if (isTrap) begin
      psw_q[int_accept_pkg::PSW_IE_BIT] <= 1'b0;
      depth_q <= depth_q + 2'd1;
      ctx_q <= CTX_TRAP;
    end else if (acceptN) begin
      psw_q[int_accept_pkg::PSW_IE_BIT] <= 1'b0;
      psw_q[int_accept_pkg::PSW_ISP_BIT] <= 1'b0;
      depth_q <= depth_q + 2'd1;
      nmiSvc_q <= 1'b1;
      ctx_q <= CTX_NMI;
    end else if (acceptM) begin
      psw_q[int_accept_pkg::PSW_IE_BIT] <= 1'b0;
      psw_q[int_accept_pkg::PSW_ISP_BIT] <= winPrio;
      depth_q <= depth_q + 2'd1;
      ctx_q <= CTX_MASKABLE;
    end else if (instrDone) begin
      unique case (int_accept_pkg::op_t'(instrOp))
        int_accept_pkg::OP_ENABLE: psw_q[int_accept_pkg::PSW_IE_BIT] <= 1'b1;
        int_accept_pkg::OP_DISABLE: psw_q[int_accept_pkg::PSW_IE_BIT] <= 1'b0;
        int_accept_pkg::OP_TRAP_RET: begin
          psw_q <= pswStack_q[depth_q - 2'd1];
          if (depth_q != 2'd0) begin
            depth_q <= depth_q - 2'd1;
          end
          ctx_q <= CTX_NONE;
        end
        int_accept_pkg::OP_INT_RET: begin
          psw_q <= pswStack_q[depth_q - 2'd1];
          nmiSvc_q <= 1'b0;
          if (depth_q != 2'd0) begin
            depth_q <= depth_q - 2'd1;
          end
          ctx_q <= CTX_NONE;
        end
        default: begin
        end
      endcase
    end else if (pswWr) begin
      psw_q <= wData_q[7:0];
    end
  end
  // ----------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      requestFlag_q <= '0;
      nmiPend_q <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (srcEvent[i]) begin
          requestFlag_q[i] <= 1'b1;
        end else if (acceptM && idx == i[IW-1:0]) begin
          requestFlag_q[i] <= 1'b0;
        end else if (regWr && awAddr_q == int_accept_pkg::OFS_REQUEST && wStrb_q[0]) begin
          requestFlag_q[i] <= wData_q[i];
        end
      end
      if (nmiEvent) begin
        nmiPend_q <= 1'b1;
      end else if (acceptN) begin
        nmiPend_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------
  // Sequencer outputs
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      takeReq <= 1'b0;
      takeNmi <= 1'b0;
      takeTrap <= 1'b0;
      vectorLo <= '0;
      vectorHi <= '0;
      pushedPsw <= int_accept_pkg::PSW_RESET;
      maskableAcceptEnable <= 1'b0;
      inServicePriority <= 1'b1;
    end else begin
      takeTrap <= isTrap;
      takeReq <= latDone && !accNmi_q;
      takeNmi <= latDone && accNmi_q;
      maskableAcceptEnable <= psw_q[int_accept_pkg::PSW_IE_BIT];
      inServicePriority <= psw_q[int_accept_pkg::PSW_ISP_BIT];
      if (isTrap) begin
        pushedPsw <= psw_q;
        vectorLo <= int_accept_pkg::TRAP_VEC_LO;
        vectorHi <= int_accept_pkg::TRAP_VEC_HI;
      end else if (acceptN || acceptM) begin
        pushedPsw <= psw_q;
        vectorLo <= acceptN ? nmiVec_q : 8'(nmiVec_q + 8'h02 + {3'h0, idx, 1'b0});
        vectorHi <= acceptN ? 8'(nmiVec_q + 8'h01) : 8'(nmiVec_q + 8'h03 + {3'h0, idx, 1'b0});
      end
    end
  end
  // ----------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------
  assign regWr = awHave_q && wHave_q && !s_axi_bvalid;
  assign pswWr = regWr && awAddr_q == int_accept_pkg::OFS_PSW && wStrb_q[0];
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= int_accept_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wHave_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (regWr) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q > int_accept_pkg::OFS_NMI_VEC || awAddr_q == int_accept_pkg::OFS_STATUS) ?
          int_accept_pkg::RESP_SLVERR : int_accept_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      maskFlag_q <= {N{1'b1}};
      sourcePriorityFlag_q <= {N{1'b1}};
      nmiVec_q <= '0;
    end else if (regWr && wStrb_q[0]) begin
      if (awAddr_q == int_accept_pkg::OFS_MASK) maskFlag_q <= wData_q[N-1:0];
      if (awAddr_q == int_accept_pkg::OFS_PRIORITY) sourcePriorityFlag_q <= wData_q[N-1:0];
      if (awAddr_q == int_accept_pkg::OFS_NMI_VEC) nmiVec_q <= wData_q[7:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= int_accept_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= int_accept_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          int_accept_pkg::OFS_REQUEST: s_axi_rdata <= 32'(requestFlag_q);
          int_accept_pkg::OFS_MASK: s_axi_rdata <= 32'(maskFlag_q);
          int_accept_pkg::OFS_PRIORITY: s_axi_rdata <= 32'(sourcePriorityFlag_q);
          int_accept_pkg::OFS_PSW: s_axi_rdata <= 32'(psw_q);
          int_accept_pkg::OFS_STATUS: s_axi_rdata <= 32'({ctx_q, depth_q, nmiPend_q, nmiSvc_q, hold_q, latBusy});
          int_accept_pkg::OFS_NMI_VEC: s_axi_rdata <= 32'(nmiVec_q);
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= int_accept_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* hw/int_accept_pkg.sv */
// Purpose: shared constants for the interrupt acceptance block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: offsets are byte addresses
package int_accept_pkg;
  localparam int NUM_SRC = 8;
  localparam logic [7:0] TRAP_VEC_LO = 8'h3e;
  localparam logic [7:0] TRAP_VEC_HI = 8'h3f;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_BIT = 1;
  localparam logic [7:0] OFS_REQUEST = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_PRIORITY = 8'h08;
  localparam logic [7:0] OFS_PSW = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_NMI_VEC = 8'h14;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int MIN_LAT_HI = 7;
  localparam int MAX_LAT_HI = 32;
  localparam int ACCEPT_CYCLES = MIN_LAT_HI - 1;
  typedef enum logic [2:0] {
    OP_NONE, OP_TRAP, OP_TRAP_RET, OP_INT_RET, OP_ENABLE, OP_DISABLE, OP_HOLD
  } op_t;
endpackage

/* hw/int_select.sv */
// Purpose: picks the winning maskable source
// Assumes: lower index wins ties
// Notes: purely combinational
`timescale 1ns/1ps
module int_select #(
  parameter int N = 8
) (
  // Sources
  input wire logic [N-1:0] request,
  input wire logic [N-1:0] mask,
  input wire logic [N-1:0] prio,
  // Result
  output logic found,
  output logic [$clog2(N)-1:0] idx,
  output logic winPrio
);
  logic [N-1:0] elig;
  logic [N-1:0] eligHi;
  logic [N-1:0] pick;
  assign elig = request & ~mask;
  assign eligHi = elig & ~prio;
  assign pick = (|eligHi) ? eligHi : elig;
  always_comb begin
    found = |pick;
    idx = '0;
    winPrio = 1'b1;
    for (int i = N - 1; i >= 0; i--) begin
      if (pick[i]) begin
        idx = i[$clog2(N)-1:0];
        winPrio = prio[i];
      end
    end
  end
endmodule

/* hw/latency_counter.sv */
// Purpose: counts the acceptance delay
// Assumes: start pulses once per acceptance
// Notes: done pulses after the programmed count
`timescale 1ns/1ps
module latency_counter #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt_q <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_q <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule

/* test/nested_interrupt_acceptance_asserts.sv */
// Purpose: port checks for the acceptance block
// Assumes: one clock, sync reset
// Notes: bound from the bench top
`timescale 1ns/1ps
module nested_interrupt_acceptance_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Sequencer side
  input wire logic instrDone,
  input wire logic [2:0] instrOp,
  input wire logic takeReq,
  input wire logic takeNmi,
  input wire logic takeTrap,
  input wire logic [7:0] vectorLo,
  input wire logic [7:0] vectorHi,
  input wire logic maskableAcceptEnable,
  input wire logic inServicePriority
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----
  // Properties
  // ----
  property p_trap;
    instrDone && instrOp == int_accept_pkg::OP_TRAP |=> takeTrap;
  endproperty
  a_trap: assert property (p_trap) else $error("trap entry missing");
  property p_vec;
    takeTrap |-> vectorLo == int_accept_pkg::TRAP_VEC_LO && vectorHi == int_accept_pkg::TRAP_VEC_HI;
  endproperty
  a_vec: assert property (p_vec) else $error("trap vector wrong");
  property p_ie;
    takeReq || takeNmi || takeTrap |-> !maskableAcceptEnable;
  endproperty
  a_ie: assert property (p_ie) else $error("enable left set at entry");
  property p_enable;
    instrDone && instrOp == int_accept_pkg::OP_ENABLE |-> ##2 maskableAcceptEnable;
  endproperty
  a_enable: assert property (p_enable) else $error("enable op ignored");
  property p_gate;
    takeReq |-> (inServicePriority ? $past(maskableAcceptEnable, 9) : $past(maskableAcceptEnable, 8));
  endproperty
  a_gate: assert property (p_gate) else $error("accepted while disabled");
  property p_lat;
    takeReq |-> (inServicePriority ? $past(instrDone, 9) : $past(instrDone, 8));
  endproperty
  a_lat: assert property (p_lat) else $error("entry latency wrong");
  property p_isp;
    takeReq && inServicePriority |-> $past(inServicePriority, 9);
  endproperty
  a_isp: assert property (p_isp) else $error("low request nested in high");
  property p_hold;
    instrDone && instrOp inside {int_accept_pkg::OP_ENABLE, int_accept_pkg::OP_DISABLE, int_accept_pkg::OP_HOLD,
      int_accept_pkg::OP_INT_RET, int_accept_pkg::OP_TRAP_RET} |-> ##8 !(takeReq || takeNmi) ##1 !takeReq;
  endproperty
  a_hold: assert property (p_hold) else $error("holding op did not defer");
  c_high: cover property (takeReq && !inServicePriority);
  c_low: cover property (takeReq && inServicePriority);
  c_nmi: cover property (takeNmi);
endmodule

/* test/cpu_seq_model.sv */
// Purpose: instruction sequencer stand-in
// Assumes: one instruction boundary at a time
// Notes: waits out any entry before the next boundary
`timescale 1ns/1ps
module cpu_seq_model (
  // Clock
  input wire logic ref_clk,
  // Entry pulses
  input wire logic takeReq,
  input wire logic takeNmi,
  input wire logic takeTrap,
  // Boundary
  output logic instrDone,
  output logic [2:0] instrOp
);
  initial begin
    instrDone = 1'b0;
    instrOp = 3'h0;
  end
  task automatic run(input logic [2:0] op, input int slow, output int lat, output logic [2:0] kind);
    int i;
    lat = 0;
    kind = 3'h0;
    @(posedge ref_clk);
    instrDone <= 1'b1;
    instrOp <= op;
    @(posedge ref_clk);
    instrDone <= 1'b0;
    instrOp <= ~op;
    #1;
    if (takeTrap) begin
      lat = 1;
      kind = 3'h1;
    end
    for (i = 1; i <= 12 && lat == 0; i++) begin
      @(posedge ref_clk);
      #1;
      if (takeReq || takeNmi || takeTrap) begin
        lat = i;
        kind = {takeNmi, takeReq, takeTrap};
      end
    end
    repeat (slow) @(posedge ref_clk);
  endtask
endmodule

/* test/test_nested_interrupt_acceptance.sv */
// Purpose: self-checking bench for the acceptance block
// Assumes: model drives instruction boundaries
// Notes: random priorities and request sets
`timescale 1ns/1ps
module test_nested_interrupt_acceptance;
  localparam logic [7:0] V = 8'h40;
  localparam logic [1:0] OK = int_accept_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = int_accept_pkg::RESP_SLVERR;
  logic ref_clk, rst_b, nmiEvent, instrDone, takeReq, takeNmi, takeTrap, maskableAcceptEnable, inServicePriority;
  logic [7:0] srcEvent, vectorLo, vectorHi, pushedPsw, s_axi_awaddr, s_axi_araddr, s, p;
  logic [2:0] instrOp;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int seed, badCount, numChecks, cycles, k, w;
  nested_interrupt_acceptance nested_interrupt_acceptance_i (.*);
  cpu_seq_model cpu_seq_model_i (.*);
  // ----
  // Helpers
  // ----
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic int winner(input logic [7:0] r, input logic [7:0] q);
    int i;
    winner = -1;
    for (i = 7; i >= 0; i--) if (r[i] && !q[i]) winner = i;
    if (winner < 0) for (i = 7; i >= 0; i--) if (r[i]) winner = i;
  endfunction
  task automatic step(input logic [2:0] op, input logic [2:0] kx, input int lx);
    int lat;
    logic [2:0] kind;
    cpu_seq_model_i.run(op, $random(seed) & 3, lat, kind);
    chk("entry kind", {29'h0, kx}, {29'h0, kind});
    chk("entry latency", lx, lat);
  endtask
  task automatic pulse(input logic [7:0] r, input logic n);
    @(posedge ref_clk);
    srcEvent <= r;
    nmiEvent <= n;
    @(posedge ref_clk);
    srcEvent <= 8'h00;
    nmiEvent <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    chk("write response", r, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    chk("read data", {24'h0, d}, s_axi_rdata);
    chk("read response", r, s_axi_rresp);
  endtask
  task automatic resetRun();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("enable", 0, maskableAcceptEnable);
    chk("in-service priority", 1, inServicePriority);
    chk("pushed status", int_accept_pkg::PSW_RESET, pushedPsw);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      printVerdict();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    {seed, badCount, numChecks, cycles} = {32'd92860, 96'h0};
    {rst_b, nmiEvent, srcEvent, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
    resetRun();
    rd(int_accept_pkg::OFS_MASK, int_accept_pkg::MASK_RESET, OK);
    rd(int_accept_pkg::OFS_PRIORITY, int_accept_pkg::PRIO_RESET, OK);
    rd(8'h3c, 8'h00, ERR);
    wr(int_accept_pkg::OFS_STATUS, 8'h00, ERR);
    wr(int_accept_pkg::OFS_NMI_VEC, V, OK);
    wr(int_accept_pkg::OFS_MASK, 8'hf0, OK);
    wr(int_accept_pkg::OFS_PRIORITY, 8'hfa, OK);
    pulse(8'h14, 1'b0);
    step(int_accept_pkg::OP_NONE, 3'h0, 0);
    step(int_accept_pkg::OP_TRAP, 3'h1, 1);
    chk("trap vector", {int_accept_pkg::TRAP_VEC_HI, int_accept_pkg::TRAP_VEC_LO}, {vectorHi, vectorLo});
    step(int_accept_pkg::OP_TRAP_RET, 3'h0, 0);
    step(int_accept_pkg::OP_ENABLE, 3'h0, 0);
    step(int_accept_pkg::OP_NONE, 3'h2, 7);
    chk("vector", V + 8'h06, vectorLo);
    chk("in-service priority", 0, inServicePriority);
    step(int_accept_pkg::OP_ENABLE, 3'h0, 0);
    pulse(8'h02, 1'b0);
    step(int_accept_pkg::OP_NONE, 3'h0, 0);
    pulse(8'h01, 1'b0);
    step(int_accept_pkg::OP_NONE, 3'h2, 7);
    step(int_accept_pkg::OP_INT_RET, 3'h0, 0);
    step(int_accept_pkg::OP_NONE, 3'h0, 0);
    step(int_accept_pkg::OP_INT_RET, 3'h0, 0);
    step(int_accept_pkg::OP_NONE, 3'h2, 8);
    chk("in-service priority", 1, inServicePriority);
    step(int_accept_pkg::OP_INT_RET, 3'h0, 0);
    for (k = 0; k < 6; k++) begin
      s = {4'h0, 4'($random(seed))} | 8'h08;
      p = {4'hf, 4'($random(seed))};
      pulse(s, 1'b0);
      wr(int_accept_pkg::OFS_PRIORITY, p, OK);
      step(int_accept_pkg::OP_NONE, 3'h0, 0);
      while (s != 8'h00) begin
        w = winner(s, p);
        step(int_accept_pkg::OP_NONE, 3'h2, 7 + p[w]);
        chk("vector", V + 8'd2 + 8'(2 * w), vectorLo);
        s[w] = 1'b0;
        step(int_accept_pkg::OP_INT_RET, 3'h0, 0);
      end
    end
    wr(int_accept_pkg::OFS_MASK, 8'he0, OK);
    step(int_accept_pkg::OP_NONE, 3'h0, 0);
    step(int_accept_pkg::OP_NONE, 3'h2, 8);
    step(int_accept_pkg::OP_INT_RET, 3'h0, 0);
    pulse(8'h01, 1'b1);
    step(int_accept_pkg::OP_NONE, 3'h4, 7);
    chk("nmi vector", V, vectorLo);
    step(int_accept_pkg::OP_ENABLE, 3'h0, 0);
    pulse(8'h00, 1'b1);
    step(int_accept_pkg::OP_NONE, 3'h0, 0);
    step(int_accept_pkg::OP_INT_RET, 3'h0, 0);
    step(int_accept_pkg::OP_NONE, 3'h4, 7);
    resetRun();
    printVerdict();
  end
endmodule
bind nested_interrupt_acceptance nested_interrupt_acceptance_asserts nested_interrupt_acceptance_asserts_i (.ref_clk,
  .rst_b, .instrDone, .instrOp, .takeReq, .takeNmi, .takeTrap, .vectorLo, .vectorHi, .maskableAcceptEnable,
  .inServicePriority);
